//--- ufsa_consts.svh
`ifndef UFSA_CONSTS_SVH
`define UFSA_CONSTS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define UFSA_ADDR_W        9
`define UFSA_DATA_W        16
`define UFSA_WORDS         512
`define UFSA_SECT_WORDS    256
`define UFSA_SECT_BITS     4096
`define UFSA_ADDR_MAX      9'h1FF
`define UFSA_ERASED        16'hFFFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define UFSA_CLK_MHZ       250
`define UFSA_PROG_TIME_US  75
`define UFSA_ERASE_TIME_MS 500
`define UFSA_PROG_CYC      (`UFSA_PROG_TIME_US * `UFSA_CLK_MHZ)
`define UFSA_ERASE_CYC     (`UFSA_ERASE_TIME_MS * 1000 * `UFSA_CLK_MHZ)

`endif

//--- ufsa_pkg.sv
package ufsa_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        S_IDLE,
        S_PROG,
        S_ERASE
    } ufsa_state_t;

    typedef enum logic [1:0] {
        TOP_READ,
        TOP_PROG,
        TOP_ERASE
    } ufsa_test_op_t;

endpackage : ufsa_pkg

//--- ufsa_if.sv
`timescale 1ns/1ps
`include "ufsa_consts.svh"

interface ufsa_if;
    logic                    wr_en;
    logic                    wr_erase;
    logic [`UFSA_ADDR_W-1:0] wr_addr;
    logic [`UFSA_DATA_W-1:0] wr_data;
    logic [`UFSA_ADDR_W-1:0] rd_addr_link;
    logic [`UFSA_DATA_W-1:0] rd_word_link;
    logic [`UFSA_ADDR_W-1:0] rd_addr_test;
    logic [`UFSA_DATA_W-1:0] rd_word_test;

    modport ctrl (
        output wr_en, wr_erase, wr_addr, wr_data, rd_addr_link, rd_addr_test,
        input  rd_word_link, rd_word_test
    );

    modport array (
        input  wr_en, wr_erase, wr_addr, wr_data, rd_addr_link, rd_addr_test,
        output rd_word_link, rd_word_test
    );
endinterface : ufsa_if

//--- ufsa_array.sv
`timescale 1ns/1ps
`include "ufsa_consts.svh"

module ufsa_array (
    // Clock
    input  wire logic mclk_in,
    // Array port
    ufsa_if.array     bus
);

    // ----------------------------------------
    // Storage, no reset: contents survive
    // ----------------------------------------
    logic [`UFSA_DATA_W-1:0] mem [0:`UFSA_WORDS-1];  // see R03 see R04

    // Program clears bits, erase sets them
    always_ff @(posedge mclk_in) begin
        if (bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_erase ? `UFSA_ERASED : (mem[bus.wr_addr] & bus.wr_data);  // see R02
        end
    end

    assign bus.rd_word_link = mem[bus.rd_addr_link];
    assign bus.rd_word_test = mem[bus.rd_addr_test];  // see R06

endmodule : ufsa_array

//--- ufsa_top.sv
`timescale 1ns/1ps
`include "ufsa_consts.svh"

// How it works
// R01: Two sectors of 4,096 bits each
// R02: Each sector erases alone, other untouched
// R03: 512 words, 9-bit address 0 to 1FFh
// R04: Every location holds one 16-bit word
// R05: Address top bit selects sector
// R06: Reachable from logic array and test port
// R07: Logic array cannot reach configuration flash
// R08: 16-bit data register shifts toward MSB
// R09: User logic feeds serial data when writing
// R10: Data clock never above 10 MHz
// R11: Shift high: LSB takes input, MSB out
// R12: Shift low: load word at current address
// R13: 9-bit address register, loaded serially
// R14: Address clock never above 10 MHz
// R15: Shift high: one address bit shifts in
// R16: Shift low: address increments by one
// R17: Increment at top address wraps to zero
// R18: Program rise writes word, busy until done
// R19: Erase rise clears sector, busy until done; code drops an erase rise that lands in the same cycle as a program rise
// R20: No clocking or requests while busy
// R21: Serial output presents MSB first

module ufsa_top #(
    parameter int unsigned PROG_CYC  = `UFSA_PROG_CYC,
    parameter int unsigned ERASE_CYC = `UFSA_ERASE_CYC
) (
    // System
    input  wire logic                    mclk_in,
    input  wire logic                    rst_n_in,
    // Data register link
    input  wire logic                    data_reg_clock_in,
    input  wire logic                    data_shift_control_in,
    input  wire logic                    data_serial_in,
    output wire logic                    data_serial_out,
    // Address register link
    input  wire logic                    addr_reg_clock_in,
    input  wire logic                    addr_shift_control_in,
    input  wire logic                    addr_serial_in,
    // Program and erase strobes
    input  wire logic                    program_in,
    input  wire logic                    erase_in,
    output wire logic                    busy_out,
    // Boundary test access
    input  wire logic                    test_valid_in,
    input  wire logic [1:0]              test_op_in,
    input  wire logic [`UFSA_ADDR_W-1:0] test_addr_in,
    input  wire logic [`UFSA_DATA_W-1:0] test_wdata_in,
    output wire logic                    test_ready_out,
    output wire logic                    test_rvalid_out,
    output wire logic [`UFSA_DATA_W-1:0] test_rdata_out
);

    localparam int unsigned AW = `UFSA_ADDR_W;
    localparam int unsigned DW = `UFSA_DATA_W;
    localparam int unsigned SW = $clog2(`UFSA_SECT_WORDS);
    localparam int unsigned CW = $clog2(ERASE_CYC + 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic op_is(input logic [1:0] op, input ufsa_pkg::ufsa_test_op_t kind);
        return op == kind;
    endfunction : op_is

    // ----------------------------------------
    // Array and its carrier
    // ----------------------------------------
    ufsa_if u_bus ();

    ufsa_array u_array (
        .mclk_in (mclk_in),
        .bus     (u_bus.array)
    );

    // ----------------------------------------
    // Address register, address clock domain
    // ----------------------------------------
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;
    wire           addr_at_top;
    wire  [AW-1:0] addr_inc;

    assign addr_at_top = (addr_q == `UFSA_ADDR_MAX);
    assign addr_inc    = addr_at_top ? '0 : addr_q + 1'b1;  // see R16 see R17
    assign addr_d      = addr_shift_control_in ? {addr_q[AW-2:0], addr_serial_in} : addr_inc;  // see R13 see R15

    always_ff @(posedge addr_reg_clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q <= '0;
        end else begin
            addr_q <= addr_d;
        end
    end

    // Only user array words are decoded, no configuration path
    assign u_bus.rd_addr_link = addr_q;  // see R07

    // ----------------------------------------
    // Data register, data clock domain
    // ----------------------------------------
    logic [DW-1:0] data_q;
    logic [DW-1:0] data_d;

    assign data_d = data_shift_control_in ? {data_q[DW-2:0], data_serial_in} : u_bus.rd_word_link;  // see R08 see R11 see R12

    always_ff @(posedge data_reg_clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_q <= '0;
        end else begin
            data_q <= data_d;
        end
    end

    assign data_serial_out = data_q[DW-1];  // see R11 see R21

    // ----------------------------------------
    // Strobe synchronisers, system clock
    // ----------------------------------------
    logic [1:0] prog_sync_q;
    logic [1:0] erase_sync_q;
    logic       prog_prev_q;
    logic       erase_prev_q;
    wire        prog_rise;
    wire        erase_rise;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prog_sync_q  <= '0;
            erase_sync_q <= '0;
            prog_prev_q  <= 1'b0;
            erase_prev_q <= 1'b0;
        end else begin
            prog_sync_q  <= {prog_sync_q[0], program_in};
            erase_sync_q <= {erase_sync_q[0], erase_in};
            prog_prev_q  <= prog_sync_q[1];
            erase_prev_q <= erase_sync_q[1];
        end
    end

    assign prog_rise  = prog_sync_q[1] & ~prog_prev_q;
    assign erase_rise = erase_sync_q[1] & ~erase_prev_q;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    ufsa_pkg::ufsa_state_t state_q;
    ufsa_pkg::ufsa_state_t state_d;
    logic [CW-1:0]         cnt_q;
    logic [CW-1:0]         cnt_d;
    logic [SW:0]           idx_q;
    logic [SW:0]           idx_d;
    logic [AW-1:0]         op_addr_q;
    logic [DW-1:0]         op_data_q;
    logic                  busy_q;
    logic                  test_rvalid_q;
    logic [DW-1:0]         test_rdata_q;

    wire          idle;
    wire          link_prog_go;
    wire          link_erase_go;
    wire          link_go;
    wire          test_take;
    wire          test_read_go;
    wire          prog_go;
    wire          erase_go;
    wire [AW-1:0] go_addr;
    wire [DW-1:0] go_data;
    wire          prog_first;
    wire          erase_walk;

    // Edges that land while busy are dropped
    assign idle          = (state_q == ufsa_pkg::S_IDLE);
    assign link_prog_go  = idle & prog_rise;  // see R18 see R20
    assign link_erase_go = idle & erase_rise & ~prog_rise;  // see R19 see R20
    assign link_go       = link_prog_go | link_erase_go;
    assign test_take     = idle & test_valid_in & ~link_go;  // see R06
    assign test_read_go  = test_take & op_is(test_op_in, ufsa_pkg::TOP_READ);
    assign prog_go       = link_prog_go | (test_take & op_is(test_op_in, ufsa_pkg::TOP_PROG));
    assign erase_go      = link_erase_go | (test_take & op_is(test_op_in, ufsa_pkg::TOP_ERASE));
    assign go_addr       = link_go ? addr_q : test_addr_in;
    assign go_data       = link_go ? data_q : test_wdata_in;
    assign test_ready_out = idle & ~link_go;

    // ----------------------------------------
    // Program and erase sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        idx_d   = idx_q;
        case (state_q)
            ufsa_pkg::S_IDLE: begin
                if (prog_go) begin
                    state_d = ufsa_pkg::S_PROG;
                    cnt_d   = CW'(PROG_CYC - 1);
                end else if (erase_go) begin
                    state_d = ufsa_pkg::S_ERASE;
                    cnt_d   = CW'(ERASE_CYC - 1);
                    idx_d   = '0;
                end
            end
            ufsa_pkg::S_PROG: begin
                if (cnt_q == '0) begin
                    state_d = ufsa_pkg::S_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ufsa_pkg::S_ERASE: begin
                if (!idx_q[SW]) begin
                    idx_d = idx_q + 1'b1;
                end
                if (cnt_q == '0) begin
                    state_d = ufsa_pkg::S_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = ufsa_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ufsa_pkg::S_IDLE;
            cnt_q   <= '0;
            idx_q   <= '0;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            idx_q   <= idx_d;
            busy_q  <= (state_d != ufsa_pkg::S_IDLE);  // see R18 see R19
        end
    end

    // Address and data are captured when a request is taken
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_addr_q <= '0;
            op_data_q <= '0;
        end else if (prog_go | erase_go) begin
            op_addr_q <= go_addr;
            op_data_q <= go_data;
        end
    end

    assign busy_out = busy_q;

    // ----------------------------------------
    // Array write port
    // ----------------------------------------
    assign prog_first = (state_q == ufsa_pkg::S_PROG) && (cnt_q == CW'(PROG_CYC - 1));
    assign erase_walk = (state_q == ufsa_pkg::S_ERASE) && !idx_q[SW];  // see R01 see R02

    assign u_bus.wr_en    = prog_first | erase_walk;  // see R18
    assign u_bus.wr_erase = erase_walk;
    assign u_bus.wr_addr  = erase_walk ? {op_addr_q[AW-1], idx_q[SW-1:0]} : op_addr_q;  // see R05 see R19
    assign u_bus.wr_data  = op_data_q;

    // ----------------------------------------
    // Test port read
    // ----------------------------------------
    assign u_bus.rd_addr_test = test_addr_in;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            test_rvalid_q <= 1'b0;
            test_rdata_q  <= '0;
        end else begin
            test_rvalid_q <= test_read_go;
            if (test_read_go) begin
                test_rdata_q <= u_bus.rd_word_test;  // see R06
            end
        end
    end

    assign test_rvalid_out = test_rvalid_q;
    assign test_rdata_out  = test_rdata_q;

    // ----------------------------------------
    // Checks, address domain
    // ----------------------------------------
    chk_addr_shift_in: assert property (  // see R15
        @(posedge addr_reg_clock_in) disable iff (!rst_n_in)
        addr_shift_control_in |=> addr_q == {$past(addr_q[AW-2:0]), $past(addr_serial_in)})
        else $error("address shift lost a bit");

    chk_addr_increment: assert property (  // see R16
        @(posedge addr_reg_clock_in) disable iff (!rst_n_in)
        !addr_shift_control_in && !addr_at_top |=> addr_q == $past(addr_q) + 1'b1)
        else $error("address did not step by one");

    chk_addr_wrap_zero: assert property (  // see R17
        @(posedge addr_reg_clock_in) disable iff (!rst_n_in)
        !addr_shift_control_in && addr_at_top |=> addr_q == '0)
        else $error("address did not wrap to zero");

    // ----------------------------------------
    // Checks, data domain
    // ----------------------------------------
    chk_data_shift_lsb: assert property (  // see R08
        @(posedge data_reg_clock_in) disable iff (!rst_n_in)
        data_shift_control_in |=> data_q == {$past(data_q[DW-2:0]), $past(data_serial_in)})
        else $error("data shift wrong");

    chk_data_load_word: assert property (  // see R12
        @(posedge data_reg_clock_in) disable iff (!rst_n_in)
        !data_shift_control_in |=> data_q == $past(u_bus.rd_word_link))
        else $error("data load missed array word");

    chk_serial_msb_out: assert property (  // see R21
        @(posedge data_reg_clock_in) disable iff (!rst_n_in)
        data_shift_control_in |=> data_serial_out == $past(data_q[DW-2]))
        else $error("serial output not next msb");

    // ----------------------------------------
    // Checks, system domain
    // ----------------------------------------
    chk_prog_busy_hold: assert property (  // see R18
        @(posedge mclk_in) disable iff (!rst_n_in)
        prog_go |=> busy_out [*8])
        else $error("busy dropped during program");

    chk_prog_write_word: assert property (  // see R18
        @(posedge mclk_in) disable iff (!rst_n_in)
        prog_go |=> u_bus.wr_en && !u_bus.wr_erase && u_bus.wr_addr == $past(go_addr)
                    && u_bus.wr_data == $past(go_data))
        else $error("program did not write selected word");

    chk_busy_release: assert property (  // see R18 see R19
        @(posedge mclk_in) disable iff (!rst_n_in)
        !idle && cnt_q == '0 |=> !busy_out && idle)
        else $error("busy not released at end");

    chk_erase_sector_sel: assert property (  // see R05
        @(posedge mclk_in) disable iff (!rst_n_in)
        erase_go |=> u_bus.wr_erase && u_bus.wr_addr[AW-1] == $past(go_addr[AW-1]))
        else $error("erase hit wrong sector");

    chk_erase_walk_end: assert property (  // see R19
        @(posedge mclk_in) disable iff (!rst_n_in)
        erase_walk && idx_q[SW-1:0] == '1 |=> !u_bus.wr_en && busy_out)
        else $error("erase walk overran sector");

    chk_test_read_word: assert property (  // see R06
        @(posedge mclk_in) disable iff (!rst_n_in)
        test_read_go |=> test_rvalid_out && test_rdata_out == $past(u_bus.rd_word_test))
        else $error("test read returned wrong word");

endmodule : ufsa_top

//--- ufsa_link_model.sv
`timescale 1ns/1ps
`include "ufsa_consts.svh"

module ufsa_link_model (
    // Status from the block
    input  wire logic busy_in,
    input  wire logic dret_in,
    // Data register link
    output logic      dclk_out,
    output logic      dshift_out,
    output logic      dser_out,
    // Address register link
    output logic      aclk_out,
    output logic      ashift_out,
    output logic      aser_out,
    // Strobes
    output logic      prog_out,
    output logic      erase_out
);
    // ----------------------------------------
    // Link timing: 126.3 ns period (62.5 ns high, 63.8 ns low), stopped between frames
    // ----------------------------------------
    localparam realtime HALF = 62.5;

    initial begin
        dclk_out   = 1'b0;
        dshift_out = 1'b0;
        dser_out   = 1'b0;
        aclk_out   = 1'b0;
        ashift_out = 1'b0;
        aser_out   = 1'b0;
        prog_out   = 1'b0;
        erase_out  = 1'b0;
    end

    // One link edge; nothing is clocked while the block is busy
    task automatic link_step(input logic use_d, input logic ds, input logic din,
                        input logic use_a, input logic as, input logic ain);
        wait (busy_in == 1'b0);
        #1.3;
        dshift_out = ds;
        dser_out   = din;
        ashift_out = as;
        aser_out   = ain;
        #(HALF);
        dclk_out = use_d;
        aclk_out = use_a;
        #(HALF);
        dclk_out = 1'b0;
        aclk_out = 1'b0;
        dser_out = ~din;
        aser_out = ~ain;
    endtask : link_step

    task automatic set_addr(input logic [`UFSA_ADDR_W-1:0] a);
        for (int i = `UFSA_ADDR_W - 1; i >= 0; i--) begin
            link_step(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, a[i]);
        end
    endtask : set_addr

    task automatic incr_addr();
        // Serial address bit high: must be ignored on increment
        link_step(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask : incr_addr

    task automatic write_word(input logic [`UFSA_DATA_W-1:0] w);
        for (int i = `UFSA_DATA_W - 1; i >= 0; i--) begin
            link_step(1'b1, 1'b1, w[i], 1'b0, 1'b0, 1'b0);
        end
    endtask : write_word

    task automatic read_word(output logic [`UFSA_DATA_W-1:0] w);
        // Serial data bit high: must be ignored on parallel load
        link_step(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        w[`UFSA_DATA_W-1] = dret_in;
        for (int i = `UFSA_DATA_W - 2; i >= 0; i--) begin
            link_step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            w[i] = dret_in;
        end
    endtask : read_word

    task automatic strobe(input logic is_erase);
        wait (busy_in == 1'b0);
        prog_out  = ~is_erase;
        erase_out = is_erase;
        #(2 * HALF);
        prog_out  = 1'b0;
        erase_out = 1'b0;
    endtask : strobe
endmodule : ufsa_link_model

//--- user_flash_serial_access_tb.sv
`timescale 1ns/1ps
`include "ufsa_consts.svh"

module user_flash_serial_access_tb;
    localparam int unsigned PCYC = 16;
    localparam int unsigned ECYC = 300;

    logic                    mclk_in;
    logic                    rst_n_in;
    logic                    test_valid_in;
    logic [1:0]              test_op_in;
    logic [`UFSA_ADDR_W-1:0] test_addr_in;
    logic [`UFSA_DATA_W-1:0] test_wdata_in;
    wire  logic              dclk, dshift, dser, dso, aclk, ashift, aser, prog, erase, busy;
    wire  logic              test_ready_out, test_rvalid_out;
    wire  logic [`UFSA_DATA_W-1:0] test_rdata_out;
    int                      n_mismatch = 0;
    int                      n_tests = 0;
    int                      cyc = 0;
    logic [`UFSA_DATA_W-1:0] w;

    initial mclk_in = 1'b0;
    always #2 mclk_in = ~mclk_in;

    ufsa_top #(.PROG_CYC(PCYC), .ERASE_CYC(ECYC)) DUT (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .data_reg_clock_in(dclk), .data_shift_control_in(dshift),
        .data_serial_in(dser), .data_serial_out(dso),
        .addr_reg_clock_in(aclk), .addr_shift_control_in(ashift),
        .addr_serial_in(aser), .program_in(prog), .erase_in(erase),
        .busy_out(busy), .test_valid_in(test_valid_in), .test_op_in(test_op_in),
        .test_addr_in(test_addr_in), .test_wdata_in(test_wdata_in),
        .test_ready_out(test_ready_out), .test_rvalid_out(test_rvalid_out),
        .test_rdata_out(test_rdata_out)
    );

    ufsa_link_model LINK (
        .busy_in(busy), .dret_in(dso), .dclk_out(dclk), .dshift_out(dshift),
        .dser_out(dser), .aclk_out(aclk), .ashift_out(ashift), .aser_out(aser),
        .prog_out(prog), .erase_out(erase)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [`UFSA_DATA_W-1:0] got, input logic [`UFSA_DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge mclk_in);
            n++;
        end
    endtask : wait_idle

    // Request held until ready is seen high at a rising edge
    task automatic tp(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wait_idle();
        @(posedge mclk_in);
        test_valid_in <= 1'b1;
        test_op_in    <= op;
        test_addr_in  <= a;
        test_wdata_in <= d;
        @(posedge mclk_in);
        while (test_ready_out !== 1'b1 && n < 2000) begin
            n++;
            @(posedge mclk_in);
        end
        test_valid_in <= 1'b0;
    endtask : tp

    task automatic tp_read(input logic [8:0] a, input logic [15:0] exp);
        tp(2'h0, a, 16'h0000);
        @(negedge mclk_in);
        chk({15'h0000, test_rvalid_out}, 16'h0001);
        chk(test_rdata_out, exp);
    endtask : tp_read

    // Busy length after a test-port request, refused while busy
    task automatic busy_len(input int unsigned exp);
        int n;
        n = 0;
        @(negedge mclk_in);
        chk({15'h0000, test_ready_out}, 16'h0000);
        while (busy === 1'b1 && n < 2000) begin
            n++;
            @(negedge mclk_in);
        end
        chk(n[15:0], exp[15:0]);
    endtask : busy_len

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({12'h000, busy, dso, test_ready_out, test_rvalid_out}, 16'h0002);
        chk(test_rdata_out, 16'h0000);
    endtask : t_reset

    task automatic t_erase_all();
        tp(2'h2, 9'h000, 16'h0000);
        busy_len(ECYC);
        tp(2'h2, 9'h100, 16'h0000);
        busy_len(ECYC);
        tp_read(9'h000, `UFSA_ERASED);
        tp_read(9'h0FF, `UFSA_ERASED);
        tp_read(9'h100, `UFSA_ERASED);
        tp_read(9'h1FF, `UFSA_ERASED);
    endtask : t_erase_all

    task automatic t_link_write();
        LINK.set_addr(9'h0A5);
        LINK.write_word(16'hA53C);
        chk({15'h0000, dso}, 16'h0001);
        LINK.strobe(1'b0);
        wait_idle();
        tp_read(9'h0A5, 16'hA53C);
        LINK.read_word(w);
        chk(w, 16'hA53C);
    endtask : t_link_write

    task automatic t_increment();
        tp(2'h1, 9'h1FF, 16'h1234);
        busy_len(PCYC);
        tp(2'h1, 9'h000, 16'h5678);
        busy_len(PCYC);
        tp(2'h1, 9'h0FF, 16'h00F0);
        tp(2'h1, 9'h100, 16'h0F00);
        wait_idle();
        LINK.set_addr(9'h1FF);
        LINK.read_word(w);
        chk(w, 16'h1234);
        LINK.incr_addr();
        LINK.read_word(w);
        chk(w, 16'h5678);
        LINK.set_addr(9'h0FF);
        LINK.read_word(w);
        chk(w, 16'h00F0);
        LINK.incr_addr();
        LINK.read_word(w);
        chk(w, 16'h0F00);
    endtask : t_increment

    task automatic t_sector_erase();
        LINK.set_addr(9'h1C3);
        LINK.strobe(1'b1);
        wait_idle();
        tp_read(9'h100, `UFSA_ERASED);
        tp_read(9'h1FF, `UFSA_ERASED);
        tp_read(9'h0A5, 16'hA53C);
        tp_read(9'h000, 16'h5678);
    endtask : t_sector_erase

    task automatic t_refused();
        int hits;
        hits = 0;
        tp(2'h1, 9'h155, 16'h3C3C);
        tp(2'h2, 9'h000, 16'h0000);
        @(posedge mclk_in);
        test_valid_in <= 1'b1;
        test_op_in    <= 2'h0;
        repeat (6) begin
            @(negedge mclk_in);
            hits += int'(test_rvalid_out === 1'b1);
        end
        @(posedge mclk_in);
        test_valid_in <= 1'b0;
        chk(hits[15:0], 16'h0000);
        tp_read(9'h0A5, `UFSA_ERASED);
        tp_read(9'h100, `UFSA_ERASED);
        tp_read(9'h155, 16'h3C3C);
    endtask : t_refused

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n_in      = 1'b0;
        test_valid_in = 1'b0;
        test_op_in    = 2'h0;
        test_addr_in  = 9'h000;
        test_wdata_in = 16'h0000;
        repeat (4) @(posedge mclk_in);
        t_reset();
        rst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        t_erase_all();
        t_link_write();
        t_increment();
        t_sector_erase();
        t_refused();
        wrap_up();
    end
endmodule : user_flash_serial_access_tb
